// ==== logic/io_mux_pin_function_select.sv ====
// How it works
// - pin one function 000 floats the pin, 001 gives the speed LED, 010 wake, 100/101 timestamp tx/rx, 110 low, 111 high.
// - pin one function sits in bits 2:0, is writable, and is loaded from the function strap during reset.
// - pin one function 011 drives the clock chosen by bits 6:4 of its register, same encoding as the collision pin.
// - collision pin function in bits 2:0 resets to 000 for normal collision and 001 gives the alternate LED output.
// - collision pin codes 010, 100, 101, 110, 111 give wake, timestamp tx, timestamp rx, low and high.
// - collision pin function 011 drives the clock chosen by bits 6:4 of its register, which reset to 000.
// - clock code 000 is the MAC interface clock, 001 the crystal input, 010 the 25 MHz reference, 011 and 101 reserved.
// - clock code 100 is the 50 MHz RMII master reference, 110 a free 125 MHz clock, 111 the recovered 125 MHz clock.
// - the MAC interface clock runs at 25 MHz in MII, 50 MHz in RMII and 25 MHz in RGMII mode.
// - in RMII master mode the RMII reference choice is the MAC interface clock itself.
// - fiber config bit 0 set means signal detect active low, clear (reset) means active high.
// - with active-high polarity the fiber link drops while signal detect reads low.
// - with active-low polarity the fiber link drops while signal detect reads high.
// - signal detection on pin one works only if the enable strap was caught high at reset.
//
// The Avalon-MM slave port was chosen for this implementation.
`timescale 1ns/1ns
module io_mux_pin_function_select (
	input  wire logic                     core_clk,
	input  wire logic                     nrst,
	input  wire logic [12:0]              avs_address,
	input  wire logic                     avs_read,
	input  wire logic                     avs_write,
	input  wire logic [31:0]              avs_writedata,
	input  wire logic [3:0]               avs_byteenable,
	output logic [31:0]                   avs_readdata,
	output logic                          avs_waitrequest,
	input  wire logic [2:0]               pin_one_default_strap,
	input  wire logic                     signal_detect_enable_strap,
	input  wire io_mux_pkg::pin_sources_s pin_one_sources,
	input  wire io_mux_pkg::pin_sources_s collision_sources,
	input  wire io_mux_pkg::clk_sources_s clocks,
	input  wire logic                     rmii_master_mode,
	input  wire logic                     multipurpose_pin_one_in,
	output logic                          multipurpose_pin_one_out,
	output logic                          multipurpose_pin_one_oe_n,
	output logic                          collision_pin_out,
	output logic                          fiber_link_drop
);
	import io_mux_pkg::*;

	// ----------------------------------------
	// state
	// ----------------------------------------
	pin_cfg_s    pin_one_cfg;
	pin_cfg_s    collision_cfg;
	logic [15:0] fiber_general_config;
	logic        ack;
	logic [2:0]  strap_s1;
	logic [2:0]  strap_s2;
	logic        signal_detect_enable_strap_s1;
	logic        signal_detect_enable_strap_s2;
	logic        signal_detect_enable_strap_latched;
	logic        sd_s1;
	logic        sd_s2;
	logic        pin_one_clk;
	logic        collision_clk;
	logic        hit_pin_one;
	logic        hit_collision;
	logic        hit_fiber;
	logic        wr_fire;
	logic [31:0] next_readdata;

	// ----------------------------------------
	// pin synchronisers
	// ----------------------------------------
	always_ff @(posedge core_clk) begin
		strap_s1 <= pin_one_default_strap;
		strap_s2 <= strap_s1;
		signal_detect_enable_strap_s1 <= signal_detect_enable_strap;
		signal_detect_enable_strap_s2 <= signal_detect_enable_strap_s1;
		sd_s1    <= multipurpose_pin_one_in;
		sd_s2    <= sd_s1;
	end

	// ----------------------------------------
	// bus decode
	// ----------------------------------------
	assign hit_pin_one   = avs_address == {IDX_PIN_ONE, 2'b00};
	assign hit_collision = avs_address == {IDX_COLLISION, 2'b00};
	assign hit_fiber     = avs_address == {IDX_FIBER, 2'b00};
	assign wr_fire       = avs_write && ack;
	assign avs_waitrequest = (avs_read || avs_write) && !ack;

	always_ff @(posedge core_clk) begin
		if (!nrst) begin
			ack <= 1'b0;
		end else begin
			ack <= (avs_read || avs_write) && !ack;
		end
	end

	always_comb begin
		next_readdata = 32'h0;
		if (hit_pin_one) begin
			next_readdata[SRC_LSB +: 3]  = pin_one_cfg.clk_src;
			next_readdata[FUNC_LSB +: 3] = pin_one_cfg.func;
		end else if (hit_collision) begin
			next_readdata[SRC_LSB +: 3]  = collision_cfg.clk_src;
			next_readdata[FUNC_LSB +: 3] = collision_cfg.func;
		end else if (hit_fiber) begin
			next_readdata[15:0] = fiber_general_config;
		end
	end

	always_ff @(posedge core_clk) begin
		if (!nrst) begin
			avs_readdata <= 32'h0;
		end else if (avs_read && !ack) begin
			avs_readdata <= next_readdata;
		end
	end

	// ----------------------------------------
	// configuration registers
	// ----------------------------------------
	always_ff @(posedge core_clk) begin
		if (!nrst) begin
			pin_one_cfg.func    <= pin_func_e'(strap_s2);
			pin_one_cfg.clk_src <= clk_src_e'(SRC_RST);
		end else if (wr_fire && hit_pin_one && avs_byteenable[0]) begin
			pin_one_cfg.func    <= pin_func_e'(avs_writedata[FUNC_LSB +: 3]);
			pin_one_cfg.clk_src <= clk_src_e'(avs_writedata[SRC_LSB +: 3]);
		end
	end

	always_ff @(posedge core_clk) begin
		if (!nrst) begin
			collision_cfg.func    <= pin_func_e'(COL_FUNC_RST);
			collision_cfg.clk_src <= clk_src_e'(SRC_RST);
		end else if (wr_fire && hit_collision && avs_byteenable[0]) begin
			collision_cfg.func    <= pin_func_e'(avs_writedata[FUNC_LSB +: 3]);
			collision_cfg.clk_src <= clk_src_e'(avs_writedata[SRC_LSB +: 3]);
		end
	end

	always_ff @(posedge core_clk) begin
		if (!nrst) begin
			fiber_general_config <= FIBER_RST;
		end else if (wr_fire && hit_fiber) begin
			if (avs_byteenable[0]) begin
				fiber_general_config[7:0] <= avs_writedata[7:0];
			end
			if (avs_byteenable[1]) begin
				fiber_general_config[15:8] <= avs_writedata[15:8];
			end
		end
	end

	// ----------------------------------------
	// fiber signal detect
	// ----------------------------------------
	always_ff @(posedge core_clk) begin
		if (!nrst) begin
			signal_detect_enable_strap_latched <= signal_detect_enable_strap_s2;
		end
	end

	always_ff @(posedge core_clk) begin
		if (!nrst) begin
			fiber_link_drop <= 1'b0;
		end else begin
			fiber_link_drop <= signal_detect_enable_strap_latched &&
				(fiber_general_config[POLARITY_BIT] ? sd_s2 : !sd_s2);
		end
	end

	// ----------------------------------------
	// clock selection and pin drivers
	// ----------------------------------------
	clock_source_select u_pin_one_clk (
		.src              (pin_one_cfg.clk_src),
		.clocks           (clocks),
		.rmii_master_mode (rmii_master_mode),
		.clk_out          (pin_one_clk)
	);

	clock_source_select u_collision_clk (
		.src              (collision_cfg.clk_src),
		.clocks           (clocks),
		.rmii_master_mode (rmii_master_mode),
		.clk_out          (collision_clk)
	);

	pin_function_mux #(
		.ZERO_IS_TRISTATE (1'b1)
	) u_pin_one_mux (
		.core_clk (core_clk),
		.nrst     (nrst),
		.func     (pin_one_cfg.func),
		.sources  (pin_one_sources),
		.sel_clk  (pin_one_clk),
		.pin_out  (multipurpose_pin_one_out),
		.pin_oe_n (multipurpose_pin_one_oe_n)
	);

	pin_function_mux #(
		.ZERO_IS_TRISTATE (1'b0)
	) u_collision_mux (
		.core_clk (core_clk),
		.nrst     (nrst),
		.func     (collision_cfg.func),
		.sources  (collision_sources),
		.sel_clk  (collision_clk),
		.pin_out  (collision_pin_out),
		.pin_oe_n ()
	);

	// ----------------------------------------
	// checks
	// ----------------------------------------
	sequence s_pin_one_held(pin_func_e f);
		(pin_one_cfg.func == f) ##1 (pin_one_cfg.func != FN_CLOCK);
	endsequence

	sequence s_col_held(pin_func_e f);
		(collision_cfg.func == f) ##1 (collision_cfg.func != FN_CLOCK);
	endsequence

	sequence s_sd_sample(logic pol, logic level);
		signal_detect_enable_strap_latched && (fiber_general_config[POLARITY_BIT] == pol) && (sd_s2 == level);
	endsequence

	a_pin_one_float: assert property (@(posedge core_clk) disable iff (!nrst)
		(pin_one_cfg.func == FN_NORMAL) |=> multipurpose_pin_one_oe_n)
		else $error("pin one not floating in tristate code");

	a_pin_one_drive: assert property (@(posedge core_clk) disable iff (!nrst)
		(pin_one_cfg.func != FN_NORMAL) |=> !multipurpose_pin_one_oe_n)
		else $error("pin one not driven");

	a_pin_one_high: assert property (@(posedge core_clk) disable iff (!nrst)
		s_pin_one_held(FN_HIGH) |-> multipurpose_pin_one_out)
		else $error("pin one not high");

	a_pin_one_led: assert property (@(posedge core_clk) disable iff (!nrst)
		s_pin_one_held(FN_LED) |-> multipurpose_pin_one_out == $past(pin_one_sources.led))
		else $error("pin one not following speed led");

	a_strap_load: assert property (@(posedge core_clk)
		$rose(nrst) |-> pin_one_cfg.func == pin_func_e'($past(strap_s2)))
		else $error("pin one function not loaded from strap");

	a_pin_one_clock: assert property (@(posedge core_clk) disable iff (!nrst)
		(pin_one_cfg.func == FN_CLOCK) && (pin_one_cfg.clk_src == SRC_CRYSTAL)
		|-> multipurpose_pin_one_out == clocks.crystal_input)
		else $error("pin one not passing crystal clock");

	a_col_normal: assert property (@(posedge core_clk) disable iff (!nrst)
		s_col_held(FN_NORMAL) |-> collision_pin_out == $past(collision_sources.normal_value))
		else $error("collision pin not in normal duty");

	a_col_ts_rx: assert property (@(posedge core_clk) disable iff (!nrst)
		s_col_held(FN_TS_RX) |-> collision_pin_out == $past(collision_sources.ts_rx))
		else $error("collision pin not showing rx timestamp");

	a_col_low: assert property (@(posedge core_clk) disable iff (!nrst)
		s_col_held(FN_LOW) |-> !collision_pin_out)
		else $error("collision pin not low");

	a_col_mac_clock: assert property (@(posedge core_clk) disable iff (!nrst)
		(collision_cfg.func == FN_CLOCK) && (collision_cfg.clk_src == SRC_MAC_IF)
		|-> collision_pin_out == clocks.mac_interface_clock)
		else $error("collision pin not passing mac clock");

	a_rmii_ref_mac: assert property (@(posedge core_clk) disable iff (!nrst)
		(collision_cfg.func == FN_CLOCK) && (collision_cfg.clk_src == SRC_RMII_REF) && rmii_master_mode
		|-> collision_pin_out == clocks.mac_interface_clock)
		else $error("rmii reference differs from mac clock in master mode");

	a_drop_active_high: assert property (@(posedge core_clk) disable iff (!nrst)
		s_sd_sample(1'b0, 1'b0) |=> fiber_link_drop)
		else $error("no link drop on low detect");

	a_drop_active_low: assert property (@(posedge core_clk) disable iff (!nrst)
		s_sd_sample(1'b1, 1'b1) |=> fiber_link_drop)
		else $error("no link drop on high detect");

	a_detect_disabled: assert property (@(posedge core_clk) disable iff (!nrst)
		!signal_detect_enable_strap_latched [*2] |-> !fiber_link_drop)
		else $error("link drop without detect strap");

	a_pin_one_wake: assert property (@(posedge core_clk) disable iff (!nrst)
		s_pin_one_held(FN_WAKE) |-> multipurpose_pin_one_out == $past(pin_one_sources.wake))
		else $error("pin one not showing wake");

	a_col_led: assert property (@(posedge core_clk) disable iff (!nrst)
		s_col_held(FN_LED) |-> collision_pin_out == $past(collision_sources.led))
		else $error("collision pin not showing alternate led");

	a_col_high: assert property (@(posedge core_clk) disable iff (!nrst)
		s_col_held(FN_HIGH) |-> collision_pin_out)
		else $error("collision pin not high");

	a_rsvd_clock: assert property (@(posedge core_clk) disable iff (!nrst)
		(collision_cfg.func == FN_CLOCK) && (collision_cfg.clk_src inside {SRC_RSVD_3, SRC_RSVD_5})
		|-> !collision_pin_out)
		else $error("reserved clock code not held low");

	a_rmii_ref_plain: assert property (@(posedge core_clk) disable iff (!nrst)
		(collision_cfg.func == FN_CLOCK) && (collision_cfg.clk_src == SRC_RMII_REF) && !rmii_master_mode
		|-> collision_pin_out == clocks.rmii_ref_50m_clk)
		else $error("rmii reference not passed outside master mode");

	a_bus_answer: assert property (@(posedge core_clk) disable iff (!nrst)
		$rose(avs_read || avs_write) |-> avs_waitrequest ##1 !avs_waitrequest)
		else $error("bus answer not in second cycle");

endmodule : io_mux_pin_function_select

// ==== logic/io_mux_pkg.sv ====
package io_mux_pkg;

	// ----------------------------------------
	// register indices (byte address = 4 * index)
	// ----------------------------------------
	localparam logic [10:0] IDX_PIN_ONE   = 11'h462;
	localparam logic [10:0] IDX_COLLISION = 11'h463;
	localparam logic [10:0] IDX_FIBER     = 11'h465;
	localparam int          ADDR_W        = 13;

	// ----------------------------------------
	// field positions and reset values
	// ----------------------------------------
	localparam int          FUNC_LSB      = 0;
	localparam int          SRC_LSB       = 4;
	localparam int          POLARITY_BIT  = 0;
	localparam logic [2:0]  COL_FUNC_RST  = 3'h0;
	localparam logic [2:0]  SRC_RST       = 3'h0;
	localparam logic [15:0] FIBER_RST     = 16'hff00;

	// ----------------------------------------
	// pin function codes
	// ----------------------------------------
	typedef enum logic [2:0] {
		FN_NORMAL  = 3'h0,
		FN_LED     = 3'h1,
		FN_WAKE    = 3'h2,
		FN_CLOCK   = 3'h3,
		FN_TS_TX   = 3'h4,
		FN_TS_RX   = 3'h5,
		FN_LOW     = 3'h6,
		FN_HIGH    = 3'h7
	} pin_func_e;

	// ----------------------------------------
	// clock source codes
	// ----------------------------------------
	typedef enum logic [2:0] {
		SRC_MAC_IF    = 3'h0,
		SRC_CRYSTAL   = 3'h1,
		SRC_REF_25M   = 3'h2,
		SRC_RSVD_3    = 3'h3,
		SRC_RMII_REF  = 3'h4,
		SRC_RSVD_5    = 3'h5,
		SRC_FREE_125M = 3'h6,
		SRC_RECOVERED = 3'h7
	} clk_src_e;

	typedef struct packed {
		clk_src_e  clk_src;
		pin_func_e func;
	} pin_cfg_s;

	typedef struct packed {
		logic normal_value;
		logic led;
		logic wake;
		logic ts_tx;
		logic ts_rx;
	} pin_sources_s;

	typedef struct packed {
		logic mac_interface_clock;
		logic crystal_input;
		logic ref_25m_clk;
		logic rmii_ref_50m_clk;
		logic free_125m_clk;
		logic recovered_125m_clk;
	} clk_sources_s;

endpackage : io_mux_pkg

// ==== logic/clock_source_select.sv ====
`timescale 1ns/1ns
module clock_source_select (
	input  wire io_mux_pkg::clk_src_e     src,
	input  wire io_mux_pkg::clk_sources_s clocks,
	input  wire logic                     rmii_master_mode,
	output logic                          clk_out
);
	import io_mux_pkg::*;

	// ----------------------------------------
	// clock source decode
	// ----------------------------------------
	always_comb begin
		unique case (src)
			SRC_MAC_IF:    clk_out = clocks.mac_interface_clock;
			SRC_CRYSTAL:   clk_out = clocks.crystal_input;
			SRC_REF_25M:   clk_out = clocks.ref_25m_clk;
			SRC_RMII_REF:  clk_out = rmii_master_mode ? clocks.mac_interface_clock
			                                          : clocks.rmii_ref_50m_clk;
			SRC_FREE_125M: clk_out = clocks.free_125m_clk;
			SRC_RECOVERED: clk_out = clocks.recovered_125m_clk;
			default:       clk_out = 1'b0;
		endcase
	end

endmodule : clock_source_select

// ==== logic/pin_function_mux.sv ====
`timescale 1ns/1ns
module pin_function_mux #(
	parameter logic ZERO_IS_TRISTATE = 1'b0
) (
	input  wire logic                     core_clk,
	input  wire logic                     nrst,
	input  wire io_mux_pkg::pin_func_e    func,
	input  wire io_mux_pkg::pin_sources_s sources,
	input  wire logic                     sel_clk,
	output logic                          pin_out,
	output logic                          pin_oe_n
);
	import io_mux_pkg::*;

	logic level;
	logic next_level;

	// ----------------------------------------
	// function decode
	// ----------------------------------------
	always_comb begin
		unique case (func)
			FN_NORMAL: next_level = ZERO_IS_TRISTATE ? 1'b0 : sources.normal_value;
			FN_LED:    next_level = sources.led;
			FN_WAKE:   next_level = sources.wake;
			FN_CLOCK:  next_level = 1'b0;
			FN_TS_TX:  next_level = sources.ts_tx;
			FN_TS_RX:  next_level = sources.ts_rx;
			FN_LOW:    next_level = 1'b0;
			FN_HIGH:   next_level = 1'b1;
		endcase
	end

	always_ff @(posedge core_clk) begin
		if (!nrst) begin
			level    <= 1'b0;
			pin_oe_n <= 1'b1;
		end else begin
			level    <= next_level;
			pin_oe_n <= ZERO_IS_TRISTATE && (func == FN_NORMAL);
		end
	end

	// clock path bypasses the flop so the selected clock reaches the pin
	assign pin_out = (func == FN_CLOCK) ? sel_clk : level;

endmodule : pin_function_mux

// ==== tb/io_mux_pin_function_select_tb.sv ====
`timescale 1ns/1ns
module io_mux_pin_function_select_tb;
	import io_mux_pkg::*;

	// ----------------------------------------
	// stimulus and observed signals
	// ----------------------------------------
	logic         core_clk;
	logic         nrst;
	logic [12:0]  avs_address;
	logic         avs_read;
	logic         avs_write;
	logic [31:0]  avs_writedata;
	logic [3:0]   avs_byteenable;
	logic [31:0]  avs_readdata;
	logic         avs_waitrequest;
	logic [2:0]   pin_one_default_strap;
	logic         signal_detect_enable_strap;
	pin_sources_s pin_one_sources;
	pin_sources_s collision_sources;
	clk_sources_s clocks;
	logic         rmii_master_mode;
	logic         multipurpose_pin_one_in;
	logic         multipurpose_pin_one_out;
	logic         multipurpose_pin_one_oe_n;
	logic         collision_pin_out;
	logic         fiber_link_drop;
	int           miscompares;
	int           tests_run;
	logic [31:0]  rd;
	logic [10:0]  idx;
	logic         seen;

	initial core_clk = 1'b0;
	always #10 core_clk = ~core_clk;

	io_mux_pin_function_select DUT (
		.core_clk                   (core_clk),
		.nrst                       (nrst),
		.avs_address                (avs_address),
		.avs_read                   (avs_read),
		.avs_write                  (avs_write),
		.avs_writedata              (avs_writedata),
		.avs_byteenable             (avs_byteenable),
		.avs_readdata               (avs_readdata),
		.avs_waitrequest            (avs_waitrequest),
		.pin_one_default_strap      (pin_one_default_strap),
		.signal_detect_enable_strap (signal_detect_enable_strap),
		.pin_one_sources            (pin_one_sources),
		.collision_sources          (collision_sources),
		.clocks                     (clocks),
		.rmii_master_mode           (rmii_master_mode),
		.multipurpose_pin_one_in    (multipurpose_pin_one_in),
		.multipurpose_pin_one_out   (multipurpose_pin_one_out),
		.multipurpose_pin_one_oe_n  (multipurpose_pin_one_oe_n),
		.collision_pin_out          (collision_pin_out),
		.fiber_link_drop            (fiber_link_drop)
	);

	// ----------------------------------------
	// helpers
	// ----------------------------------------
	task automatic check(input logic [31:0] got, input logic [31:0] exp);
		tests_run++;
		if (got !== exp) begin
			miscompares++;
			$display("MISMATCH t=%0t seen=%h expected=%h", $time, got, exp);
		end
	endtask : check

	task automatic finish_test;
		$display("comparisons %0d mismatches %0d", tests_run, miscompares);
		if (miscompares == 0 && tests_run > 0) begin
			$display("Simulation passed");
		end else begin
			$display("Simulation failed");
		end
		$finish;
	endtask : finish_test

	task automatic end_test(input string name);
		$display("test %s done", name);
	endtask : end_test

	task automatic bus_write(input logic [10:0] i, input logic [15:0] d);
		@(posedge core_clk);
		avs_address <= {i, 2'b00};
		avs_writedata <= {16'h0000, d};
		avs_write <= 1'b1;
		do begin
			@(posedge core_clk);
		end while (avs_waitrequest !== 1'b0);
		avs_write <= 1'b0;
	endtask : bus_write

	task automatic bus_read(input logic [10:0] i, output logic [31:0] d);
		@(posedge core_clk);
		avs_address <= {i, 2'b00};
		avs_read <= 1'b1;
		do begin
			@(posedge core_clk);
		end while (avs_waitrequest !== 1'b0);
		d = avs_readdata;
		avs_read <= 1'b0;
	endtask : bus_read

	task automatic do_reset(input logic [2:0] s, input logic e);
		@(posedge core_clk);
		nrst <= 1'b0;
		pin_one_default_strap <= s;
		signal_detect_enable_strap <= e;
		repeat (5) @(posedge core_clk);
		nrst <= 1'b1;
	endtask : do_reset

	function automatic logic exp_func(input logic [2:0] f, input logic [4:0] s);
		case (f)
			3'h0: exp_func = s[4];
			3'h1: exp_func = s[3];
			3'h2: exp_func = s[2];
			3'h4: exp_func = s[1];
			3'h5: exp_func = s[0];
			3'h7: exp_func = 1'b1;
			default: exp_func = 1'b0;
		endcase
	endfunction : exp_func

	function automatic logic exp_clk(input logic [2:0] c, input logic [5:0] k, input logic m);
		case (c)
			3'h0: exp_clk = k[5];
			3'h1: exp_clk = k[4];
			3'h2: exp_clk = k[3];
			3'h4: exp_clk = m ? k[5] : k[2];
			3'h6: exp_clk = k[1];
			3'h7: exp_clk = k[0];
			default: exp_clk = 1'b0;
		endcase
	endfunction : exp_clk

	// ----------------------------------------
	// watchdog
	// ----------------------------------------
	initial begin
		repeat (20000) @(posedge core_clk);
		miscompares++;
		$display("watchdog expired");
		finish_test();
	end

	// ----------------------------------------
	// tests
	// ----------------------------------------
	initial begin
		nrst = 1'b0;
		avs_address = 13'h0000;
		avs_read = 1'b0;
		avs_write = 1'b0;
		avs_writedata = 32'h00000000;
		avs_byteenable = 4'hf;
		pin_one_default_strap = 3'h5;
		signal_detect_enable_strap = 1'b1;
		pin_one_sources = pin_sources_s'(5'h00);
		collision_sources = pin_sources_s'(5'h00);
		clocks = clk_sources_s'(6'h00);
		rmii_master_mode = 1'b0;
		multipurpose_pin_one_in = 1'b1;
		miscompares = 0;
		tests_run = 0;
		do_reset(3'h5, 1'b1);
		bus_read(IDX_PIN_ONE, rd);
		check(rd, 32'h00000005);
		bus_read(IDX_COLLISION, rd);
		check(rd, 32'h00000000);
		bus_read(IDX_FIBER, rd);
		check(rd, 32'h0000ff00);
		bus_read(11'h464, rd);
		check(rd, 32'h00000000);
		end_test("reset");
		for (int p = 0; p < 2; p++) begin
			idx = (p == 0) ? IDX_PIN_ONE : IDX_COLLISION;
			for (int f = 0; f < 8; f++) begin
				if (f != 3) begin
					bus_write(idx, 16'(f));
					bus_read(idx, rd);
					check(rd, 32'(f));
					for (int b = 0; b < 5; b++) begin
						@(posedge core_clk);
						pin_one_sources <= pin_sources_s'((p == 0) ? 5'(1 << b) : ~5'(1 << b));
						collision_sources <= pin_sources_s'((p == 1) ? 5'(1 << b) : ~5'(1 << b));
						repeat (2) @(posedge core_clk);
						@(negedge core_clk);
						seen = (p == 0) ? multipurpose_pin_one_out : collision_pin_out;
						if (p == 1 || f != 0) begin
							check(32'(seen), 32'(exp_func(3'(f), 5'(1 << b))));
						end
						if (p == 0) begin
							check(32'(multipurpose_pin_one_oe_n), 32'(f == 0));
						end
					end
				end
			end
		end
		end_test("functions");
		for (int p = 0; p < 2; p++) begin
			idx = (p == 0) ? IDX_PIN_ONE : IDX_COLLISION;
			for (int c = 0; c < 8; c++) begin
				bus_write(idx, {9'h000, 3'(c), 4'h3});
				bus_read(idx, rd);
				check(rd, {25'h0, 3'(c), 4'h3});
				for (int m = 0; m < 2; m++) begin
					for (int b = 0; b < 6; b++) begin
						@(posedge core_clk);
						clocks <= clk_sources_s'(6'(1 << b));
						rmii_master_mode <= 1'(m);
						@(negedge core_clk);
						seen = (p == 0) ? multipurpose_pin_one_out : collision_pin_out;
						check(32'(seen), 32'(exp_clk(3'(c), 6'(1 << b), 1'(m))));
					end
				end
				if (p == 0) begin
					check(32'(multipurpose_pin_one_oe_n), 32'h0);
				end
			end
		end
		end_test("clocks");
		for (int pol = 0; pol < 2; pol++) begin
			bus_read(IDX_FIBER, rd);
			bus_write(IDX_FIBER, {rd[15:1], 1'(pol)});
			bus_read(IDX_FIBER, rd);
			check(rd, 32'h0000ff00 | 32'(pol));
			for (int lvl = 0; lvl < 2; lvl++) begin
				@(posedge core_clk);
				multipurpose_pin_one_in <= 1'(lvl);
				repeat (4) @(posedge core_clk);
				@(negedge core_clk);
				check(32'(fiber_link_drop), 32'((pol == 1) ? (lvl == 1) : (lvl == 0)));
			end
		end
		@(posedge core_clk);
		avs_byteenable <= 4'h2;
		bus_write(IDX_FIBER, 16'h00fe);
		bus_write(IDX_PIN_ONE, 16'h0000);
		avs_byteenable <= 4'hf;
		bus_read(IDX_FIBER, rd);
		check(rd, 32'h00000001);
		bus_read(IDX_PIN_ONE, rd);
		check(rd, 32'h00000073);
		end_test("fiber");
		do_reset(3'h2, 1'b0);
		bus_read(IDX_PIN_ONE, rd);
		check(rd, 32'h00000002);
		bus_read(IDX_FIBER, rd);
		check(rd, 32'h0000ff00);
		for (int lvl = 0; lvl < 2; lvl++) begin
			@(posedge core_clk);
			multipurpose_pin_one_in <= 1'(lvl);
			repeat (4) @(posedge core_clk);
			@(negedge core_clk);
			check(32'(fiber_link_drop), 32'h0);
		end
		end_test("strap");
		finish_test();
	end

endmodule : io_mux_pin_function_select_tb
